// ### src/tpg_control.sv
/*
  Two-pin general-purpose control: pin control register, pin drivers,
  input readback, level-change events and the interrupt event and mask pair.
  Assumes single-cycle read and write strobes from the host side on clock.
  Assumes pin inputs are asynchronous; they are synchronised before any use.
  Read answers come one cycle after the strobe; no wait states are inserted.
*/
`default_nettype none
module tpg_control (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port
  input wire logic regSpace,
  input wire logic [tpg_pkg::ADDR_W-1:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  output logic regRvalid,
  // Pins: index 0 is aux_pin_a, index 1 is aux_pin_b
  input wire logic [1:0] auxPinIn,
  output logic [1:0] auxPinOut,
  output logic [1:0] auxPinOe,
  // Interrupt request toward the host
  output logic irqRequest
);
  logic [31:0] auxPinControl;
  logic [31:0] irqEvent;
  logic [31:0] irqMask;
  logic [31:0] next_auxPinControl;
  logic [31:0] next_irqEvent;
  logic [31:0] next_irqMask;
  logic [31:0] next_regRdata;
  logic next_regRvalid;
  logic [1:0] next_auxPinOut;
  logic [1:0] next_auxPinOe;
  logic next_irqRequest;
  logic [1:0] pinLevel;
  logic [1:0] pinChange;
  logic [1:0] invert;
  logic [1:0] driveValue;
  logic [1:0] outEnable;
  logic [1:0] eventEnable;
  logic gpEvent;
  logic [31:0] gpEventVec;
  logic selControl;
  logic selEventSet;
  logic selEventClear;
  logic selMaskSet;
  logic selMaskClear;

  // Address match within one space
  function automatic logic hit(input logic space, input logic [tpg_pkg::ADDR_W-1:0] addr,
                               input logic wantSpace, input logic [tpg_pkg::ADDR_W-1:0] off);
    hit = (space == wantSpace) && (addr == off);
  endfunction

  // Address decode, shared by the write and read paths
  assign selControl = hit(regSpace, regAddr, tpg_pkg::CFG_SPACE, tpg_pkg::AUX_PIN_CONTROL_OFF);
  assign selEventSet = hit(regSpace, regAddr, tpg_pkg::MEM_SPACE, tpg_pkg::IRQ_EVENT_SET_OFF);
  assign selEventClear = hit(regSpace, regAddr, tpg_pkg::MEM_SPACE, tpg_pkg::IRQ_EVENT_CLEAR_OFF);
  assign selMaskSet = hit(regSpace, regAddr, tpg_pkg::MEM_SPACE, tpg_pkg::IRQ_MASK_SET_OFF);
  assign selMaskClear = hit(regSpace, regAddr, tpg_pkg::MEM_SPACE, tpg_pkg::IRQ_MASK_CLEAR_OFF);

  // Input synchroniser and level-change detector
  tpg_sync_edge #(
    .WIDTH(2)
  ) u_sync (
    .clock(clock),
    .resetn(resetn),
    .pinRaw(auxPinIn),
    .pinLevel(pinLevel),
    .pinChange(pinChange)
  );

  // Field extraction from the pin control register
  assign invert = {auxPinControl[tpg_pkg::PIN_B_POLARITY_INVERT_BIT],
                   auxPinControl[tpg_pkg::PIN_A_POLARITY_INVERT_BIT]};
  assign driveValue = {auxPinControl[tpg_pkg::PIN_B_VALUE_BIT],
                       auxPinControl[tpg_pkg::PIN_A_VALUE_BIT]};
  assign outEnable = {auxPinControl[tpg_pkg::PIN_B_OUTPUT_ENABLE_BIT],
                      auxPinControl[tpg_pkg::PIN_A_OUTPUT_ENABLE_BIT]};
  assign eventEnable = {auxPinControl[tpg_pkg::PIN_B_EVENT_ENABLE_BIT],
                        auxPinControl[tpg_pkg::PIN_A_EVENT_ENABLE_BIT]};

  // General event from either enabled pin
  assign gpEvent = |(pinChange & eventEnable);
  assign gpEventVec = {31'h00000000, gpEvent} << tpg_pkg::GP_EVENT_BIT;

  // Pin control register next value; only documented bits store
  always_comb begin
    next_auxPinControl = auxPinControl;
    if (regWrite && selControl) begin
      // Reserved positions are masked off before they reach a flop
      next_auxPinControl = regWdata & tpg_pkg::AUX_PIN_CONTROL_WMASK;
    end
  end

  // Pin control register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      auxPinControl <= tpg_pkg::AUX_PIN_CONTROL_RESET;
    end else begin
      auxPinControl <= next_auxPinControl;
    end
  end

  // Event and mask set/clear pairs; hardware set wins over a clear
  always_comb begin
    next_irqEvent = irqEvent;
    next_irqMask = irqMask;
    if (regWrite && selEventSet) begin
      next_irqEvent = irqEvent | regWdata;
    end
    if (regWrite && selEventClear) begin
      next_irqEvent = irqEvent & ~regWdata;
    end
    if (regWrite && selMaskSet) begin
      next_irqMask = irqMask | regWdata;
    end
    if (regWrite && selMaskClear) begin
      next_irqMask = irqMask & ~regWdata;
    end
    // A level change in the clearing cycle must not be lost
    next_irqEvent = next_irqEvent | gpEventVec;
  end

  // Event and mask registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irqEvent <= tpg_pkg::IRQ_EVENT_RESET;
      irqMask <= tpg_pkg::IRQ_MASK_RESET;
    end else begin
      irqEvent <= next_irqEvent;
      irqMask <= next_irqMask;
    end
  end

  // Pin drivers; a disabled pin also carries zero toward the pad
  always_comb begin
    next_auxPinOut = (driveValue ^ invert) & outEnable;
    next_auxPinOe = outEnable;
  end

  // Pin driver registers, so the pads see flop outputs only
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      auxPinOut <= 2'h0;
      auxPinOe <= 2'h0;
    end else begin
      auxPinOut <= next_auxPinOut;
      auxPinOe <= next_auxPinOe;
    end
  end

  // Request only for events that software has unmasked
  always_comb begin
    next_irqRequest = |(irqEvent & irqMask);
  end

  // Request register; one cycle behind the event register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irqRequest <= 1'h0;
    end else begin
      irqRequest <= next_irqRequest;
    end
  end

  // Read data; pin value bits show the live, polarity-corrected input
  always_comb begin
    next_regRdata = 32'h00000000;
    next_regRvalid = regRead;
    if (regRead) begin
      // Unmapped addresses fall through and answer zero
      if (selControl) begin
        next_regRdata = auxPinControl & tpg_pkg::AUX_PIN_CONTROL_WMASK;
        next_regRdata[tpg_pkg::PIN_B_VALUE_BIT] = pinLevel[1] ^ invert[1];
        next_regRdata[tpg_pkg::PIN_A_VALUE_BIT] = pinLevel[0] ^ invert[0];
      end else if (selEventSet) begin
        next_regRdata = irqEvent;
      end else if (selEventClear) begin
        next_regRdata = irqEvent & irqMask;
      end else if (selMaskSet || selMaskClear) begin
        next_regRdata = irqMask;
      end
    end
  end

  // Read answer registers; data fall back to zero when idle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 32'h00000000;
      regRvalid <= 1'h0;
    end else begin
      regRdata <= next_regRdata;
      regRvalid <= next_regRvalid;
    end
  end
endmodule : tpg_control
`default_nettype wire

// ### src/tpg_pkg.sv
/*
  Package for the two-pin general-purpose control block: register offsets,
  field positions, reset values and widths shared by the design files.
  Assumes a 32-bit register port with separate configuration and memory spaces.
*/
`default_nettype none
package tpg_pkg;
  // Address width and spaces of the register port
  localparam int ADDR_W = 12;
  localparam logic CFG_SPACE = 1'h0;
  localparam logic MEM_SPACE = 1'h1;

  // Configuration space offset of the pin control register
  localparam logic [ADDR_W-1:0] AUX_PIN_CONTROL_OFF = 12'h0FC;

  // Memory space offsets of the interrupt event and mask pairs
  localparam logic [ADDR_W-1:0] IRQ_EVENT_SET_OFF = 12'h080;
  localparam logic [ADDR_W-1:0] IRQ_EVENT_CLEAR_OFF = 12'h084;
  localparam logic [ADDR_W-1:0] IRQ_MASK_SET_OFF = 12'h088;
  localparam logic [ADDR_W-1:0] IRQ_MASK_CLEAR_OFF = 12'h08C;

  // Field positions in the pin control register
  localparam int PIN_B_EVENT_ENABLE_BIT = 31;
  localparam int PIN_B_POLARITY_INVERT_BIT = 29;
  localparam int PIN_B_OUTPUT_ENABLE_BIT = 28;
  localparam int PIN_B_VALUE_BIT = 24;
  localparam int PIN_A_EVENT_ENABLE_BIT = 23;
  localparam int PIN_A_POLARITY_INVERT_BIT = 21;
  localparam int PIN_A_OUTPUT_ENABLE_BIT = 20;
  localparam int PIN_A_VALUE_BIT = 16;

  // Bits of the pin control register that software can store
  localparam logic [31:0] AUX_PIN_CONTROL_WMASK = 32'hB1B10000;
  localparam logic [31:0] AUX_PIN_CONTROL_RESET = 32'h00000000;

  // Bit of the general-purpose pin event in the event and mask registers
  localparam int GP_EVENT_BIT = 12;
  localparam logic [31:0] IRQ_EVENT_RESET = 32'h00000000;
  localparam logic [31:0] IRQ_MASK_RESET = 32'h00000000;

  // Synchroniser depth ahead of the edge detector
  localparam int SYNC_STAGES = 2;
endpackage : tpg_pkg
`default_nettype wire

// ### src/tpg_sync_edge.sv
/*
  Pin input synchroniser with level-change detector, one lane per pin.
  Assumes asynchronous pin levels and a single system clock.
*/
`default_nettype none
module tpg_sync_edge #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Raw pins and conditioned results
  input wire logic [WIDTH-1:0] pinRaw,
  output logic [WIDTH-1:0] pinLevel,
  output logic [WIDTH-1:0] pinChange
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stable;
  logic [WIDTH-1:0] last;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_stable;
  logic [WIDTH-1:0] next_last;

  // Next values of the two sync stages and the history stage
  always_comb begin
    next_meta = pinRaw;
    next_stable = meta;
    next_last = stable;
  end

  // Registers; the first stage feeds only the second
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta <= '0;
      stable <= '0;
      last <= '0;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
      last <= next_last;
    end
  end

  // One pulse per level change after synchronisation
  assign pinLevel = stable;
  assign pinChange = stable ^ last;
endmodule : tpg_sync_edge
`default_nettype wire

// ### sim/tpg_control_asserts.sv
/* Port checker for tpg_control.
   Assumes the bind below and one clock domain with resetn active low. */
`default_nettype none
module tpg_control_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port
  input wire logic regSpace,
  input wire logic [tpg_pkg::ADDR_W-1:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regWdata,
  input wire logic [31:0] regRdata,
  input wire logic regRvalid,
  // Pins and request
  input wire logic [1:0] auxPinIn,
  input wire logic [1:0] auxPinOut,
  input wire logic [1:0] auxPinOe,
  input wire logic irqRequest
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] wd1, wd2;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // Write data two cycles back, for pin checks
  always_ff @(posedge clock) begin
    wd1 <= regWdata;
    wd2 <= wd1;
  end
  // Control word accesses
  sequence cfgWrite;
    regWrite && regSpace == tpg_pkg::CFG_SPACE && regAddr == tpg_pkg::AUX_PIN_CONTROL_OFF;
  endsequence
  sequence cfgRead;
    regRead && regSpace == tpg_pkg::CFG_SPACE && regAddr == tpg_pkg::AUX_PIN_CONTROL_OFF;
  endsequence
  a_oe_after_write: assert property (cfgWrite |-> ##2
    auxPinOe == {wd2[28], wd2[20]}) else $error("Pin enable differs from written word");
  a_drive_after_write: assert property (cfgWrite |-> ##2
    auxPinOut == ({wd2[24] ^ wd2[29], wd2[16] ^ wd2[21]} & {wd2[28], wd2[20]}))
    else $error("Pin drive differs from written word");
  a_out_gated: assert property ((auxPinOut & ~auxPinOe) == 2'h0)
    else $error("Pin drive while disabled");
  a_rsvd_zero: assert property (cfgRead |=> regRvalid &&
    (regRdata & ~tpg_pkg::AUX_PIN_CONTROL_WMASK) == 32'h0) else $error("Reserved bits set");
  a_read_idle: assert property (!regRead |=> !regRvalid && regRdata == 32'h0)
    else $error("Read answer without read");
  a_unmapped_zero: assert property (regRead && regSpace == tpg_pkg::CFG_SPACE &&
    regAddr != tpg_pkg::AUX_PIN_CONTROL_OFF |=> regRvalid && regRdata == 32'h0)
    else $error("Unmapped read not zero");
  a_mask_clear_irq: assert property (regWrite && regSpace == tpg_pkg::MEM_SPACE &&
    regAddr == tpg_pkg::IRQ_MASK_CLEAR_OFF && regWdata == 32'hFFFFFFFF |-> ##2 !irqRequest)
    else $error("Request with mask cleared");
  a_reset_idle: assert property ($rose(resetn) |-> auxPinOe == 2'h0 && !irqRequest)
    else $error("Outputs active after reset");
endmodule // tpg_control_asserts
bind tpg_control tpg_control_asserts u_chk (.clock(clock), .resetn(resetn),
  .regSpace(regSpace), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
  .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid), .auxPinIn(auxPinIn),
  .auxPinOut(auxPinOut), .auxPinOe(auxPinOe), .irqRequest(irqRequest));
`default_nettype wire

// ### sim/tpg_pin_model.sv
/* Board side of the two pins: a source of its own on each pin.
   Assumes the block wins wherever its output enable is high. */
`default_nettype none
module tpg_pin_model (
  // Block side
  input wire logic [1:0] auxPinOut,
  input wire logic [1:0] auxPinOe,
  // Level of the board source
  input wire logic [1:0] boardLevel,
  // Resolved wire
  output logic [1:0] pinWire
);
  timeunit 1ns;
  timeprecision 1ps;
  // Block drive where enabled, board source elsewhere
  assign pinWire = (auxPinOe & auxPinOut) | (~auxPinOe & boardLevel);
endmodule // tpg_pin_model
`default_nettype wire

// ### sim/tb_two_pin_gpio_control.sv
/* Self-checking bench for tpg_control.
   Assumes the pin model and the bound checker are compiled alongside. */
`default_nettype none
module tb_two_pin_gpio_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, resetn = 1'b0, regSpace = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic regRvalid, irqRequest;
  logic [tpg_pkg::ADDR_W-1:0] regAddr = 12'h000;
  logic [31:0] regWdata = 32'h0, regRdata;
  logic [1:0] auxPinIn, auxPinOut, auxPinOe, boardLevel = 2'h0;
  int error_cnt = 0, checks_done = 0;
  // Clock and parts
  initial forever #2 clock = ~clock;
  tpg_control DUT (.clock(clock), .resetn(resetn), .regSpace(regSpace), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
    .regRvalid(regRvalid), .auxPinIn(auxPinIn), .auxPinOut(auxPinOut), .auxPinOe(auxPinOe),
    .irqRequest(irqRequest));
  tpg_pin_model u_pins (.auxPinOut(auxPinOut), .auxPinOe(auxPinOe), .boardLevel(boardLevel),
    .pinWire(auxPinIn));
  // Compare, bus cycles and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic sp, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clock);
    #1 regSpace = sp;
    regAddr = ad;
    regWdata = d;
    regWrite = 1'b1;
    @(posedge clock);
    #1 regWrite = 1'b0;
  endtask
  task automatic rd(input logic sp, input logic [11:0] ad, input logic [31:0] exp);
    @(posedge clock);
    #1 regSpace = sp;
    regAddr = ad;
    regRead = 1'b1;
    @(posedge clock);
    #1 regRead = 1'b0;
    check(regRdata, exp);
    check({31'h0, regRvalid}, 32'h1);
  endtask
  task automatic wait_irq;
    for (int i = 0; i < 12 && irqRequest !== 1'b1; i++) @(posedge clock);
    #1 check({31'h0, irqRequest}, 32'h1);
  endtask
  task automatic test_done;
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Reset values and an unmapped place
  task automatic t_reset;
    check({30'h0, auxPinOe}, 32'h0);
    rd(1'b0, 12'h0FC, 32'h0);
    rd(1'b0, 12'h0F8, 32'h0);
  endtask
  // Event register set and clear ports
  task automatic t_setclr;
    wr(1'b1, 12'h080, 32'h5);
    wr(1'b1, 12'h080, 32'h0);
    rd(1'b1, 12'h080, 32'h5);
    wr(1'b1, 12'h084, 32'h4);
    rd(1'b1, 12'h080, 32'h1);
  endtask
  // Drive, enable, inversion, reserved bits and readback
  task automatic t_pins;
    wr(1'b0, 12'h0FC, 32'hFFFFFFFF);
    repeat (5) @(posedge clock);
    check({28'h0, auxPinOe, auxPinOut}, 32'hC);
    rd(1'b0, 12'h0FC, 32'hB1B10000);
    wr(1'b0, 12'h0FC, 32'h00110000);
    boardLevel = 2'h2;
    repeat (5) @(posedge clock);
    check({28'h0, auxPinOe, auxPinOut}, 32'h5);
    rd(1'b0, 12'h0FC, 32'h01110000);
    boardLevel = 2'h0;
    repeat (5) @(posedge clock);
    rd(1'b0, 12'h0FC, 32'h00110000);
  endtask
  // Level-change events, masking and clearing
  task automatic t_events;
    wr(1'b0, 12'h0FC, 32'h80000000);
    wr(1'b1, 12'h084, 32'hFFFFFFFF);
    wr(1'b1, 12'h088, 32'h1000);
    boardLevel = 2'h2;
    wait_irq();
    rd(1'b1, 12'h080, 32'h1000);
    rd(1'b1, 12'h084, 32'h1000);
    rd(1'b1, 12'h088, 32'h1000);
    wr(1'b1, 12'h084, 32'h1000);
    boardLevel = 2'h3;
    repeat (10) @(posedge clock);
    check({31'h0, irqRequest}, 32'h0);
    wr(1'b0, 12'h0FC, 32'h00800000);
    boardLevel = 2'h2;
    wait_irq();
    wr(1'b1, 12'h08C, 32'hFFFFFFFF);
    repeat (3) @(posedge clock);
    check({31'h0, irqRequest}, 32'h0);
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clock);
    #1 resetn = 1'b1;
    t_reset();
    t_setclr();
    t_pins();
    t_events();
    test_done();
  end
  // Watchdog well past the expected run of under a hundred cycles
  initial begin
    #20000;
    error_cnt++;
    test_done();
  end
endmodule // tb_two_pin_gpio_control
`default_nettype wire
